// ---- tdk_debounce.sv ----
// Two-stage synchroniser and tick-based debouncer for five contact inputs
`timescale 1ns/100ps
`include "tdk_map.svh"
module tdk_debounce (
  input wire logic mclk,
  input wire logic rstSync_n,
  input wire logic tick,
  input wire logic [4:0] raw,
  output logic [4:0] clean
);
  logic [4:0] syncA;
  logic [4:0] syncB;
  logic [4:0][4:0] cnt;

  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      syncA <= 5'h00;
      syncB <= 5'h00;
    end
    else
    begin
      syncA <= raw;
      syncB <= syncA;
    end
  end

  // A level must stay put for the full debounce time before it is accepted
  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      clean <= 5'h00;
      cnt <= '0;
    end
    else
    begin
      for (int i = 0; i < 5; i++)
      begin
        if (syncB[i] == clean[i])
          cnt[i] <= 5'h00;
        else if (tick)
        begin
          if (cnt[i] == `TDK_DEBOUNCE_MS - 5'h01)
          begin
            clean[i] <= syncB[i]; // RL16
            cnt[i] <= 5'h00;
          end
          else
            cnt[i] <= cnt[i] + 5'h01;
        end
      end
    end
  end

  property p_debounceTick;
    @(posedge mclk) disable iff (!rstSync_n)
    !tick |=> $stable(clean);
  endproperty
  a_debounceTick: assert property (p_debounceTick) else $error("debounced input moved off tick"); // RL16
endmodule

// ---- tdk_front_panel.sv ----
// Front-panel sequencing, keypad, totals and annunciators of the rate totaliser
// What this block does
// RL1: Run power-up sequence before any display operation
// RL2: Light every segment two seconds after delay
// RL3: Show firmware part and version two seconds
// RL4: Then start rate and total with calibration
// RL5: Function plus down shows grand total low
// RL6: Function plus up shows grand total high
// RL7: Up plus down two seconds clears total
// RL8: Down alone shows firmware part and version
// RL9: Rate on separate six-digit display
// RL10: Eight-digit total, cleared by local/remote reset
// RL11: Each pulse in run animates flow indicator two seconds
// RL12: Hold lamp when frequency below clip-off
// RL13: Reset lamp while total reset in progress
// RL14: Four buttons; alarm option may reassign them
// RL15: Remote contact over one second; held inhibits
// RL16: Synchronise, debounce, time holds on clock ticks
// RL17: Total clears leave grand total untouched
`timescale 1ns/100ps
`include "tdk_map.svh"
module tdk_front_panel #(
  parameter int TICK_CYCLES = `TDK_TICK_CYCLES,
  parameter logic [31:0] FW_PART = 32'h00000100, // Arbitrary value
  parameter logic [23:0] FW_VERSION = 24'h000001 // Arbitrary value
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire tdk_pkg::tdk_keys_t keyRaw,
  input wire logic remoteContact,
  input wire logic pulseIn,
  input wire logic localResetEn,
  input wire logic altKeyMode,
  input wire logic [15:0] clipOffMs,
  input wire logic calLoadDone,
  output logic calLoadReq,
  output tdk_pkg::tdk_keys_t keys,
  output tdk_pkg::tdk_panel_t panel
);
  logic [1:0] rstPipe;
  logic rstSync_n;
  logic [16:0] divCnt;
  logic tick;
  tdk_pkg::tdk_state_t state;
  tdk_pkg::tdk_state_t next_state;
  logic [11:0] phaseMs;
  logic [2:0] pulsePipe;
  logic pulseEdge;
  logic remoteHeld;
  logic running;
  logic counting;
  logic [31:0] total;
  logic [63:0] grand;
  logic [23:0] rateBcd;
  logic [23:0] rateAcc;
  logic [11:0] gateMs;
  logic gateEnd;
  logic [63:0] totalInc;
  logic [63:0] grandInc;
  logic [63:0] rateInc;
  logic gtLow;
  logic gtHigh;
  logic idShow;
  logic comboHeld;
  logic [11:0] localMs;
  logic localFire;
  logic [11:0] remMs;
  logic remFire;
  logic clearTotal;
  logic [15:0] sincePulse;
  logic [11:0] flowMs;
  logic [11:0] flowStepMs;
  logic [1:0] flowPhase;
  tdk_pkg::tdk_panel_t next_panel;

  function automatic logic [63:0] bcdInc(input logic [63:0] v);
    logic [63:0] r;
    logic carry;
    r = v;
    carry = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      if (carry)
      begin
        if (r[i*4 +: 4] == 4'h9)
          r[i*4 +: 4] = 4'h0;
        else
        begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
    return r;
  endfunction

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstSync_n = rstPipe[1];

  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      divCnt <= 17'h00000;
    else if (tick)
      divCnt <= 17'h00000;
    else
      divCnt <= divCnt + 17'h00001;
  end
  assign tick = (divCnt == 17'(TICK_CYCLES - 1)); // RL16

  tdk_debounce u_debounce (
    .mclk(mclk),
    .rstSync_n(rstSync_n),
    .tick(tick),
    .raw({remoteContact, keyRaw}),
    .clean({remoteHeld, keys})
  ); // RL14

  // Power-up display sequence; every reset release restarts it
  always_comb
  begin
    next_state = state;
    case (state)
      tdk_pkg::INIT_DELAY:
        if (tick && phaseMs == `TDK_INIT_DELAY_MS - `TDK_MS_ONE)
          next_state = tdk_pkg::LAMP_TEST; // RL1
      tdk_pkg::LAMP_TEST:
        if (tick && phaseMs == `TDK_LAMP_MS - `TDK_MS_ONE)
          next_state = tdk_pkg::SHOW_ID; // RL2
      tdk_pkg::SHOW_ID:
        if (tick && phaseMs == `TDK_ID_MS - `TDK_MS_ONE)
          next_state = tdk_pkg::CAL_LOAD; // RL3
      tdk_pkg::CAL_LOAD:
        if (calLoadDone)
          next_state = tdk_pkg::RUN; // RL4
      tdk_pkg::RUN: next_state = tdk_pkg::RUN;
      default: next_state = tdk_pkg::INIT_DELAY;
    endcase
  end

  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      state <= tdk_pkg::INIT_DELAY; // RL1
    else
      state <= next_state;
  end

  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      phaseMs <= `TDK_MS_ZERO;
    else if (state != next_state)
      phaseMs <= `TDK_MS_ZERO;
    else if (tick)
      phaseMs <= phaseMs + `TDK_MS_ONE;
  end

  assign calLoadReq = (state == tdk_pkg::CAL_LOAD); // RL4
  assign running = (state == tdk_pkg::RUN);

  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      pulsePipe <= 3'h0;
    else
      pulsePipe <= {pulsePipe[1:0], pulseIn};
  end
  assign pulseEdge = pulsePipe[1] & ~pulsePipe[2];

  // A closed remote contact stops totalisation, so a permanent closure inhibits
  assign counting = running && !remoteHeld; // RL15
  assign totalInc = bcdInc({32'h00000000, total});
  assign grandInc = bcdInc(grand);
  assign rateInc = bcdInc({40'h0000000000, rateAcc});

  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      total <= 32'h00000000;
    else if (clearTotal)
      total <= 32'h00000000; // RL10
    else if (pulseEdge && counting)
      total <= totalInc[31:0];
  end

  // Grand total only ever counts; no local or remote reset reaches it
  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      grand <= 64'h0000000000000000;
    else if (pulseEdge && counting)
      grand <= grandInc; // RL17
  end

  // Rate is pulses per one-second gate; scaling lives elsewhere
  assign gateEnd = tick && gateMs == `TDK_RATE_GATE_MS - `TDK_MS_ONE;
  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      gateMs <= `TDK_MS_ZERO;
      rateAcc <= 24'h000000;
      rateBcd <= 24'h000000;
    end
    else if (!running)
    begin
      gateMs <= `TDK_MS_ZERO;
      rateAcc <= 24'h000000;
    end
    else
    begin
      if (gateEnd)
      begin
        gateMs <= `TDK_MS_ZERO;
        rateBcd <= rateAcc; // RL9
        rateAcc <= pulseEdge ? 24'h000001 : 24'h000000;
      end
      else
      begin
        if (tick)
          gateMs <= gateMs + `TDK_MS_ONE;
        if (pulseEdge)
          rateAcc <= rateInc[23:0];
      end
    end
  end

  // Alarm option takes the keypad over, so display-mode combinations go quiet
  assign gtLow = running && !altKeyMode && keys.func && keys.down && !keys.up; // RL14
  assign gtHigh = running && !altKeyMode && keys.func && keys.up && !keys.down;
  assign idShow = running && !altKeyMode && keys.down && !keys.up && !keys.func;
  assign comboHeld = running && !altKeyMode && localResetEn && keys.up && keys.down && !keys.func;

  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      localMs <= `TDK_MS_ZERO;
    else if (!comboHeld)
      localMs <= `TDK_MS_ZERO;
    else if (tick && localMs != `TDK_LOCAL_RESET_MS)
      localMs <= localMs + `TDK_MS_ONE; // RL16
  end
  assign localFire = comboHeld && tick && localMs == `TDK_LOCAL_RESET_MS - `TDK_MS_ONE; // RL7

  // Counter saturates one past the limit: fires only once the closure exceeds it
  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      remMs <= `TDK_MS_ZERO;
    else if (!remoteHeld || !running)
      remMs <= `TDK_MS_ZERO;
    else if (tick && remMs != `TDK_REMOTE_RESET_MS + `TDK_MS_ONE)
      remMs <= remMs + `TDK_MS_ONE;
  end
  assign remFire = remoteHeld && running && tick && remMs == `TDK_REMOTE_RESET_MS; // RL15
  assign clearTotal = localFire || remFire; // RL10

  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      sincePulse <= 16'h0000;
    else if (pulseEdge)
      sincePulse <= 16'h0000;
    else if (tick && sincePulse != `TDK_HOLD_SAT)
      sincePulse <= sincePulse + 16'h0001;
  end

  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      flowMs <= `TDK_MS_ZERO;
    else if (pulseEdge && running)
      flowMs <= `TDK_FLOW_MS; // RL11
    else if (tick && flowMs != `TDK_MS_ZERO)
      flowMs <= flowMs - `TDK_MS_ONE;
  end

  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      flowStepMs <= `TDK_MS_ZERO;
      flowPhase <= 2'h0;
    end
    else if (tick && flowMs != `TDK_MS_ZERO)
    begin
      if (flowStepMs == `TDK_FLOW_STEP_MS - `TDK_MS_ONE)
      begin
        flowStepMs <= `TDK_MS_ZERO;
        flowPhase <= flowPhase + 2'h1;
      end
      else
        flowStepMs <= flowStepMs + `TDK_MS_ONE;
    end
  end

  always_comb
  begin
    next_panel = '0;
    next_panel.blank = (state == tdk_pkg::INIT_DELAY);
    next_panel.allSegments = (state == tdk_pkg::LAMP_TEST); // RL2
    next_panel.showId = (state == tdk_pkg::SHOW_ID) || idShow; // RL3
    next_panel.rate = rateBcd; // RL9
    next_panel.total = total; // RL10
    if (next_panel.showId)
    begin
      next_panel.rate = FW_VERSION; // RL8
      next_panel.total = FW_PART;
    end
    else if (gtLow)
      next_panel.total = grand[31:0]; // RL5
    else if (gtHigh)
      next_panel.total = grand[63:32]; // RL6
    next_panel.annGrandTotal = gtLow || gtHigh;
    next_panel.annHold = running && ({16'h0000, sincePulse} > {16'h0000, clipOffMs}); // RL12
    next_panel.annReset = (comboHeld && localMs == `TDK_LOCAL_RESET_MS)
      || (remoteHeld && running && remMs == `TDK_REMOTE_RESET_MS + `TDK_MS_ONE); // RL13
    next_panel.flowActive = (flowMs != `TDK_MS_ZERO);
    next_panel.flowPhase = flowPhase;
  end

  always_ff @(posedge mclk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      panel <= '0;
    else
      panel <= next_panel;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstSync_n);

  property p_runEntry;
    (state == tdk_pkg::RUN) && ($past(state) != tdk_pkg::RUN)
      |-> $past(state) == tdk_pkg::CAL_LOAD;
  endproperty
  a_runEntry: assert property (p_runEntry) else $error("run entered outside sequence"); // RL1

  property p_lampEnd;
    (state == tdk_pkg::LAMP_TEST) && tick && (phaseMs == `TDK_LAMP_MS - `TDK_MS_ONE)
      |=> (state == tdk_pkg::SHOW_ID) ##1 !panel.allSegments && panel.showId;
  endproperty
  a_lampEnd: assert property (p_lampEnd) else $error("lamp test length wrong"); // RL2

  property p_idEnd;
    (state == tdk_pkg::SHOW_ID) && tick && (phaseMs == `TDK_ID_MS - `TDK_MS_ONE)
      |=> calLoadReq;
  endproperty
  a_idEnd: assert property (p_idEnd) else $error("identification length wrong"); // RL3

  property p_calLoad;
    calLoadReq && calLoadDone |=> running && !calLoadReq;
  endproperty
  a_calLoad: assert property (p_calLoad) else $error("calibration load not followed by run"); // RL4

  property p_gtLow;
    gtLow |=> panel.annGrandTotal && panel.total == $past(grand[31:0]);
  endproperty
  a_gtLow: assert property (p_gtLow) else $error("grand total low digits not shown"); // RL5

  property p_gtHigh;
    gtHigh |=> panel.annGrandTotal && panel.total == $past(grand[63:32]);
  endproperty
  a_gtHigh: assert property (p_gtHigh) else $error("grand total high digits not shown"); // RL6

  property p_localClear;
    localFire |=> total == 32'h00000000 ##1 panel.total == 32'h00000000 || !comboHeld;
  endproperty
  a_localClear: assert property (p_localClear) else $error("local reset did not clear total"); // RL7

  property p_idShow;
    idShow |=> panel.showId && panel.total == FW_PART && panel.rate == FW_VERSION;
  endproperty
  a_idShow: assert property (p_idShow) else $error("firmware id not shown"); // RL8

  property p_rateLatch;
    running && gateEnd |=> rateBcd == $past(rateAcc);
  endproperty
  a_rateLatch: assert property (p_rateLatch) else $error("rate not latched at gate end"); // RL9

  property p_remoteClear;
    remFire |=> total == 32'h00000000 && grand == $past(grand);
  endproperty
  a_remoteClear: assert property (p_remoteClear) else $error("remote reset wrong"); // RL10

  property p_flow;
    pulseEdge && running |=> flowMs == `TDK_FLOW_MS ##1 panel.flowActive;
  endproperty
  a_flow: assert property (p_flow) else $error("flow indicator not retriggered"); // RL11

  property p_hold;
    panel.annHold == $past(running && ({16'h0000, sincePulse} > {16'h0000, clipOffMs}));
  endproperty
  a_hold: assert property (p_hold) else $error("hold annunciator wrong"); // RL12

  property p_resetLamp;
    remFire |=> ##1 panel.annReset || !remoteHeld;
  endproperty
  a_resetLamp: assert property (p_resetLamp) else $error("reset annunciator not lit"); // RL13

  property p_altKeys;
    altKeyMode |-> !gtLow && !gtHigh && !idShow && !comboHeld;
  endproperty
  a_altKeys: assert property (p_altKeys) else $error("keypad active under alarm mode"); // RL14

  property p_inhibit;
    remoteHeld |=> total == $past(total) || total == 32'h00000000;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("total counted while inhibited"); // RL15

  property p_grandKeep;
    localFire && !pulseEdge |=> grand == $past(grand);
  endproperty
  a_grandKeep: assert property (p_grandKeep) else $error("grand total disturbed by reset"); // RL17
endmodule

// ---- tdk_front_panel_tb.sv ----
// Self-checking bench of the totaliser front panel
`timescale 1ns/100ps
module tdk_front_panel_tb;
  localparam int TC = 5;
  localparam int LIMIT = 90000;
  localparam logic [31:0] PART = 32'h00001234; // Arbitrary value
  localparam logic [23:0] VER = 24'h000056; // Arbitrary value
  localparam int TOT = 0, RATE = 1, BLK = 2, SEG = 3, SID = 4, GT = 5;
  localparam int HLD = 6, RST = 7, FLOW = 8, REQ = 9, KEY = 10, PHS = 11;
  typedef struct {int sel; logic [31:0] val;} tdk_note_t;
  logic mclk;
  logic reset_n;
  logic localResetEn;
  logic altKeyMode;
  logic [15:0] clipOffMs;
  logic calLoadReq;
  logic calLoadDone;
  logic remoteContact;
  logic pulseIn;
  tdk_pkg::tdk_keys_t keyRaw;
  tdk_pkg::tdk_keys_t keys;
  tdk_pkg::tdk_panel_t panel;
  tdk_note_t notes[$];
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  int k;
  event chkEv;

  tdk_front_panel #(.TICK_CYCLES(TC), .FW_PART(PART), .FW_VERSION(VER)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .keyRaw(keyRaw), .remoteContact(remoteContact),
    .pulseIn(pulseIn), .localResetEn(localResetEn), .altKeyMode(altKeyMode),
    .clipOffMs(clipOffMs), .calLoadDone(calLoadDone), .calLoadReq(calLoadReq),
    .keys(keys), .panel(panel)
  );

  tdk_operator_model #(.TICK_CYCLES(TC)) i_op (
    .mclk(mclk), .calLoadReq(calLoadReq), .keyRaw(keyRaw),
    .remoteContact(remoteContact), .pulseIn(pulseIn), .calLoadDone(calLoadDone)
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic conclude();
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      errors++;
      $display("unexpected at %0t: run did not finish", $time);
      conclude();
    end
  end

  function automatic logic [31:0] field(input int sel);
    case (sel)
      TOT: return panel.total;
      RATE: return {8'h00, panel.rate};
      BLK: return {31'h0, panel.blank};
      SEG: return {31'h0, panel.allSegments};
      SID: return {31'h0, panel.showId};
      GT: return {31'h0, panel.annGrandTotal};
      HLD: return {31'h0, panel.annHold};
      RST: return {31'h0, panel.annReset};
      FLOW: return {31'h0, panel.flowActive};
      PHS: return {30'h0, panel.flowPhase};
      REQ: return {31'h0, calLoadReq};
      default: return {28'h0, keys};
    endcase
  endfunction

  task automatic chk(input int sel, input logic [31:0] val);
    notes.push_back('{sel, val});
    -> chkEv;
  endtask

  // Watcher drains every note raised in this time step
  initial
  begin
    tdk_note_t nt;
    forever
    begin
      @chkEv;
      while (notes.size() > 0)
      begin
        nt = notes.pop_front();
        num_checks++;
        if (field(nt.sel) !== nt.val)
        begin
          errors++;
          $display("unexpected at %0t: item %0d is %h, want %h", $time, nt.sel,
                   field(nt.sel), nt.val);
        end
      end
    end
  end

  task automatic wait_ms(input int ms);
    repeat (ms * TC) @(posedge mclk);
    #1;
  endtask

  task automatic key_check(input logic [3:0] kv, input int sel, input logic [31:0] val);
    i_op.hold(tdk_pkg::tdk_keys_t'(kv));
    wait_ms(40);
    chk(sel, val);
    i_op.release_keys();
  endtask

  initial
  begin
    void'($urandom(32'h37F5));
    n = 1 + $urandom_range(4);
    k = 1 + $urandom_range(3);
    i_op.calDelay = 200 + $urandom_range(100);
    reset_n = 1'b0;
    localResetEn = 1'b0;
    altKeyMode = 1'b0;
    // Random clip-off stays between the 50 ms and 1.9 s hold checks
    clipOffMs = 16'(100 + $urandom_range(900));
    repeat (6) @(posedge mclk);
    #1;
    chk(TOT, 32'h0);
    chk(SEG, 32'h0);
    reset_n = 1'b1;
    wait_ms(50);
    chk(BLK, 32'h1);
    chk(SEG, 32'h0);
    // A pulse before the run phase must not reach the total
    i_op.pulse();
    wait_ms(80);
    chk(SEG, 32'h1);
    wait_ms(1900);
    chk(SEG, 32'h1);
    wait_ms(100);
    chk(SEG, 32'h0);
    chk(SID, 32'h1);
    chk(TOT, PART);
    chk(RATE, {8'h00, VER});
    wait_ms(1900);
    chk(SID, 32'h1);
    chk(REQ, 32'h0);
    wait_ms(60);
    chk(REQ, 32'h1);
    chk(SID, 32'h0);
    wait_ms(90);
    chk(REQ, 32'h0);
    chk(TOT, 32'h0);
    chk(BLK, 32'h0);
    repeat (n) i_op.pulse();
    wait_ms(30);
    chk(TOT, 32'(n));
    chk(FLOW, 32'h1);
    chk(HLD, 32'h0);
    wait_ms(1000);
    chk(RATE, 32'(n));
    wait_ms(850);
    chk(FLOW, 32'h1);
    chk(HLD, 32'h1);
    chk(PHS, 32'h3);
    wait_ms(200);
    chk(FLOW, 32'h0);
    chk(RATE, 32'h0);
    chk(TOT, 32'(n));
    key_check(4'hA, KEY, 32'hA);
    key_check(4'hA, TOT, 32'(n));
    key_check(4'hA, GT, 32'h1);
    key_check(4'hC, TOT, 32'h0);
    key_check(4'hC, GT, 32'h1);
    chk(GT, 32'h0);
    key_check(4'h2, SID, 32'h1);
    chk(SID, 32'h0);
    altKeyMode = 1'b1;
    key_check(4'h2, SID, 32'h0);
    altKeyMode = 1'b0;
    key_check(4'h6, TOT, 32'(n));
    i_op.hold(tdk_pkg::tdk_keys_t'(4'h6));
    wait_ms(2100);
    chk(TOT, 32'(n));
    chk(RST, 32'h0);
    i_op.release_keys();
    localResetEn = 1'b1;
    i_op.hold(tdk_pkg::tdk_keys_t'(4'h6));
    wait_ms(1900);
    chk(TOT, 32'(n));
    wait_ms(200);
    chk(TOT, 32'h0);
    chk(RST, 32'h1);
    i_op.release_keys();
    chk(RST, 32'h0);
    key_check(4'hA, TOT, 32'(n));
    repeat (k) i_op.pulse();
    wait_ms(30);
    chk(TOT, 32'(k));
    i_op.contact(1'b1);
    wait_ms(900);
    chk(TOT, 32'(k));
    i_op.contact(1'b0);
    wait_ms(40);
    i_op.contact(1'b1);
    wait_ms(100);
    i_op.pulse();
    chk(TOT, 32'(k));
    wait_ms(1000);
    chk(TOT, 32'h0);
    chk(RST, 32'h1);
    i_op.contact(1'b0);
    wait_ms(40);
    chk(RST, 32'h0);
    key_check(4'hA, TOT, 32'(n + k));
    conclude();
  end
endmodule

// ---- tdk_map.svh ----
// Clock period, tick length and timing counts of the totaliser front panel
`ifndef TDK_MAP_SVH
`define TDK_MAP_SVH
`define TDK_CLK_NS 10
`define TDK_TICK_NS 1000000
`define TDK_TICK_CYCLES (`TDK_TICK_NS / `TDK_CLK_NS)
// All ms counts below run on the 1 ms tick
`define TDK_INIT_DELAY_MS 12'h064
`define TDK_LAMP_MS 12'h7D0
`define TDK_ID_MS 12'h7D0
`define TDK_LOCAL_RESET_MS 12'h7D0
`define TDK_REMOTE_RESET_MS 12'h3E8
`define TDK_FLOW_MS 12'h7D0
`define TDK_FLOW_STEP_MS 12'h0FA
`define TDK_RATE_GATE_MS 12'h3E8
`define TDK_DEBOUNCE_MS 5'h14
`define TDK_MS_ZERO 12'h000
`define TDK_MS_ONE 12'h001
`define TDK_HOLD_SAT 16'hFFFF
`endif

// ---- tdk_operator_model.sv ----
// Operator buttons, remote contact, flowmeter pulses and calibration store
`timescale 1ns/100ps
module tdk_operator_model #(
  parameter int TICK_CYCLES = 5
) (
  input wire logic mclk,
  input wire logic calLoadReq,
  output tdk_pkg::tdk_keys_t keyRaw,
  output logic remoteContact,
  output logic pulseIn,
  output logic calLoadDone
);
  int calDelay = 0;

  initial
  begin
    keyRaw = '0;
    remoteContact = 1'b0;
    pulseIn = 1'b0;
  end

  task automatic wait_ms(input int ms);
    repeat (ms * TICK_CYCLES) @(posedge mclk);
    #1;
  endtask

  // Contacts chatter for a few ms, shorter than any debounce window
  task automatic hold(input tdk_pkg::tdk_keys_t k);
    repeat (3)
    begin
      keyRaw = tdk_pkg::tdk_keys_t'(4'($urandom));
      wait_ms(1);
    end
    keyRaw = k;
  endtask

  task automatic release_keys();
    hold('0);
    wait_ms(40);
  endtask

  // The caller decides how long the closure is held
  task automatic contact(input logic v);
    repeat (3)
    begin
      remoteContact = 1'($urandom);
      wait_ms(1);
    end
    remoteContact = v;
  endtask

  task automatic pulse();
    pulseIn = 1'b1;
    wait_ms(1);
    pulseIn = 1'b0;
    wait_ms(19);
  endtask

  // Storage answers after calDelay cycles with a one-cycle done
  initial
  begin
    calLoadDone = 1'b0;
    forever
    begin
      @(posedge mclk);
      if (calLoadReq === 1'b1)
      begin
        repeat (calDelay) @(posedge mclk);
        #1;
        calLoadDone = 1'b1;
        @(posedge mclk);
        #1;
        calLoadDone = 1'b0;
      end
    end
  end
endmodule

// ---- tdk_pkg.sv ----
// Types shared by the totaliser front-panel design
package tdk_pkg;
  typedef enum logic [2:0] {INIT_DELAY, LAMP_TEST, SHOW_ID, CAL_LOAD, RUN} tdk_state_t;

  typedef struct packed {
    logic func;
    logic up;
    logic down;
    logic enter;
  } tdk_keys_t;

  typedef struct packed {
    logic [23:0] rate;
    logic [31:0] total;
    logic blank;
    logic allSegments;
    logic showId;
    logic annGrandTotal;
    logic annHold;
    logic annReset;
    logic flowActive;
    logic [1:0] flowPhase;
  } tdk_panel_t;
endpackage
